// *** bbe_pkg.sv ***
// constants and operation codes for the bit and branch execution unit
// assumes a decoder upstream that turns opcodes into bbe_op_e values
// Function
// - clear, set, invert carry or one addressed bit, other bits kept
// - carry AND addressed bit or its inverse, result to carry only
// - carry OR addressed bit or its inverse, result to carry only
// - move addressed bit to carry, or carry to addressed bit
// - short jump loads pc with next pc plus signed displacement
// - indirect jump goes to data pointer plus accumulator
// - branch when accumulator zero, or when nonzero, else fall through
// - branch when carry set, or when clear, carry unchanged
// - branch when addressed bit one, or zero, bit unchanged
// - bit one: branch and clear it; bit zero: fall through
// - compare acc/register/indirect byte with operand, branch when unequal
// - indirect compare fetches byte through pointer register, then compares
// - decrement register or location, write back, branch when nonzero
// - no-op takes one cycle and changes nothing but pc advance
// - displacement is signed 8 bits, from start of next instruction
package bbe_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W_DEF = 16;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] HI_SHIFT = 8'h08;

  typedef enum logic [4:0] {
    OP_NOP, OP_CLR_C, OP_SET_C, OP_CPL_C, OP_CLR_BIT, OP_SET_BIT, OP_CPL_BIT,
    OP_AND_BIT_C, OP_AND_NBIT_C, OP_OR_BIT_C, OP_OR_NBIT_C, OP_MOV_BIT_C, OP_MOV_C_BIT,
    OP_SHORT_JUMP, OP_INDIRECT_JUMP, OP_ABS_JUMP,
    OP_ACC_ZERO, OP_ACC_NONZERO, OP_CARRY, OP_NO_CARRY, OP_BIT_ONE, OP_BIT_ZERO,
    OP_BIT_TEST_CLEAR, OP_CMP, OP_CMP_INDIRECT, OP_DEC_BRANCH,
    OP_CALL, OP_RETURN, OP_INT_RETURN
  } bbe_op_e;
endpackage

// *** bbe_exec.sv ***
// bit manipulation and program branch execution unit
// assumes the core datapath presents operands with opValid and applies the
// registered write-back strobes; internal ram answers one cycle after memReq
`timescale 1ns/1ps
module bbe_exec import bbe_pkg::*; #(
  parameter int PC_W = PC_W_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  // operation request
  input wire logic opValid,
  input bbe_op_e opCode,
  input wire logic [PC_W-1:0] pcNext,
  input wire logic [7:0] relOffset,
  input wire logic [PC_W-1:0] target,
  // datapath operands
  input wire logic [7:0] acc,
  input wire logic [PC_W-1:0] dataPointer,
  input wire logic carryIn,
  input wire logic [7:0] bitAddr,
  input wire logic bitValue,
  input wire logic [7:0] operandA,
  input wire logic [7:0] operandB,
  input wire logic [7:0] ptrAddr,
  input wire logic [7:0] spIn,
  input wire logic [7:0] memRdata,
  // status
  output logic busy,
  output logic done,
  // write-back
  output logic pcLoad,
  output logic [PC_W-1:0] pcValue,
  output logic carryWe,
  output logic carryOut,
  output logic bitWe,
  output logic [7:0] bitAddrOut,
  output logic bitOut,
  output logic byteWe,
  output logic [7:0] byteOut,
  output logic spWe,
  output logic [7:0] spOut,
  output logic prioRelease,
  // internal ram port
  output logic memReq,
  output logic memWe,
  output logic [7:0] memAddr,
  output logic [7:0] memWdata
);
  if (PC_W <= DATA_W || PC_W > 2 * DATA_W) begin : gBadWidth
    $error("PC_W must lie between 9 and 16");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_RD_WAIT, ST_CMP_DATA, ST_PUSH_HI, ST_POP_HI, ST_POP_LO} bbe_state_e;

  function automatic logic [PC_W-1:0] relTarget(input logic [PC_W-1:0] pc, input logic [7:0] rel);
    relTarget = pc + {{(PC_W-8){rel[7]}}, rel};
  endfunction

  bbe_state_e state, next_state, afterState, next_afterState;
  logic [PC_W-1:0] savedPc, next_savedPc, savedTarget, next_savedTarget;
  logic [7:0] savedRel, next_savedRel, savedImm, next_savedImm, savedSp, next_savedSp;
  logic [7:0] savedHi, next_savedHi;
  logic savedInt, next_savedInt;
  logic next_busy, next_done, next_pcLoad, next_carryWe, next_carryOut, next_bitWe, next_bitOut;
  logic next_byteWe, next_spWe, next_prioRelease, next_memReq, next_memWe;
  logic [PC_W-1:0] next_pcValue;
  logic [7:0] next_bitAddrOut, next_byteOut, next_spOut, next_memAddr, next_memWdata;
  logic take;
  logic [7:0] decValue;

  assign take = opValid && !busy && clkEn;
  assign decValue = operandA - SP_STEP;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_afterState = afterState;
    next_savedPc = savedPc;
    next_savedTarget = savedTarget;
    next_savedRel = savedRel;
    next_savedImm = savedImm;
    next_savedSp = savedSp;
    next_savedHi = savedHi;
    next_savedInt = savedInt;
    next_done = 1'b0;
    next_pcLoad = 1'b0;
    next_pcValue = pcValue;
    next_carryWe = 1'b0;
    next_carryOut = carryOut;
    next_bitWe = 1'b0;
    next_bitAddrOut = bitAddrOut;
    next_bitOut = bitOut;
    next_byteWe = 1'b0;
    next_byteOut = byteOut;
    next_spWe = 1'b0;
    next_spOut = spOut;
    next_prioRelease = 1'b0;
    next_memReq = 1'b0;
    next_memWe = 1'b0;
    next_memAddr = memAddr;
    next_memWdata = memWdata;
    unique case (state)
      ST_IDLE: begin
        if (opValid) begin
          next_done = 1'b1;
          next_bitAddrOut = bitAddr;
          next_pcValue = relTarget(pcNext, relOffset);
          next_savedPc = pcNext;
          next_savedTarget = target;
          next_savedRel = relOffset;
          next_savedImm = operandB;
          next_savedSp = spIn;
          next_savedInt = (opCode == OP_INT_RETURN);
          unique case (opCode)
            OP_NOP: ; // pc advance belongs to the fetch logic
            OP_CLR_C, OP_SET_C, OP_CPL_C: begin
              next_carryWe = 1'b1;
              next_carryOut = (opCode == OP_SET_C) || (opCode == OP_CPL_C && !carryIn);
            end
            OP_CLR_BIT, OP_SET_BIT, OP_CPL_BIT: begin
              // only the addressed bit is written; the datapath merges it
              next_bitWe = 1'b1;
              next_bitOut = (opCode == OP_SET_BIT) || (opCode == OP_CPL_BIT && !bitValue);
            end
            OP_AND_BIT_C, OP_AND_NBIT_C: begin
              next_carryWe = 1'b1;
              next_carryOut = carryIn && (bitValue ^ (opCode == OP_AND_NBIT_C));
            end
            OP_OR_BIT_C, OP_OR_NBIT_C: begin
              next_carryWe = 1'b1;
              next_carryOut = carryIn || (bitValue ^ (opCode == OP_OR_NBIT_C));
            end
            OP_MOV_BIT_C: begin
              next_carryWe = 1'b1;
              next_carryOut = bitValue;
            end
            OP_MOV_C_BIT: begin
              next_bitWe = 1'b1;
              next_bitOut = carryIn;
            end
            OP_SHORT_JUMP: next_pcLoad = 1'b1;
            OP_INDIRECT_JUMP: begin
              next_pcLoad = 1'b1;
              next_pcValue = dataPointer + {{(PC_W-8){1'b0}}, acc};
            end
            OP_ABS_JUMP: begin
              next_pcLoad = 1'b1;
              next_pcValue = target;
            end
            OP_ACC_ZERO: next_pcLoad = (acc == ZERO_BYTE);
            OP_ACC_NONZERO: next_pcLoad = (acc != ZERO_BYTE);
            OP_CARRY: next_pcLoad = carryIn;
            OP_NO_CARRY: next_pcLoad = !carryIn;
            OP_BIT_ONE: next_pcLoad = bitValue;
            OP_BIT_ZERO: next_pcLoad = !bitValue;
            OP_BIT_TEST_CLEAR: begin
              next_pcLoad = bitValue;
              next_bitWe = bitValue;
              next_bitOut = 1'b0;
            end
            OP_CMP: begin
              next_pcLoad = (operandA != operandB);
              next_carryWe = 1'b1;
              next_carryOut = (operandA < operandB);
            end
            OP_CMP_INDIRECT: begin
              next_done = 1'b0;
              next_memReq = 1'b1;
              next_memAddr = ptrAddr;
              next_state = ST_RD_WAIT;
              next_afterState = ST_CMP_DATA;
            end
            OP_DEC_BRANCH: begin
              next_byteWe = 1'b1;
              next_byteOut = decValue;
              next_pcLoad = (decValue != ZERO_BYTE);
            end
            OP_CALL: begin
              next_done = 1'b0;
              next_memReq = 1'b1;
              next_memWe = 1'b1;
              next_memAddr = spIn + SP_STEP;
              next_memWdata = pcNext[7:0];
              next_state = ST_PUSH_HI;
            end
            OP_RETURN, OP_INT_RETURN: begin
              next_done = 1'b0;
              next_memReq = 1'b1;
              next_memAddr = spIn;
              next_state = ST_RD_WAIT;
              next_afterState = ST_POP_HI;
            end
            default: next_done = 1'b1; // unknown codes retire as a no-op
          endcase
        end
      end
      ST_RD_WAIT: next_state = afterState;
      ST_CMP_DATA: begin
        next_done = 1'b1;
        next_pcLoad = (memRdata != savedImm);
        next_pcValue = relTarget(savedPc, savedRel);
        next_carryWe = 1'b1;
        next_carryOut = (memRdata < savedImm);
        next_state = ST_IDLE;
      end
      ST_PUSH_HI: begin
        next_memReq = 1'b1;
        next_memWe = 1'b1;
        next_memAddr = savedSp + SP_STEP + SP_STEP;
        next_memWdata = 8'(savedPc >> HI_SHIFT);
        next_spWe = 1'b1;
        next_spOut = savedSp + SP_STEP + SP_STEP;
        next_pcLoad = 1'b1;
        next_pcValue = savedTarget;
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      ST_POP_HI: begin
        next_savedHi = memRdata;
        next_memReq = 1'b1;
        next_memAddr = savedSp - SP_STEP;
        next_state = ST_RD_WAIT;
        next_afterState = ST_POP_LO;
      end
      ST_POP_LO: begin
        next_pcLoad = 1'b1;
        next_pcValue = PC_W'({savedHi, memRdata});
        next_spWe = 1'b1;
        next_spOut = savedSp - SP_STEP - SP_STEP;
        next_prioRelease = savedInt;
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
    next_busy = (next_state != ST_IDLE);
  end

  // clkEn low holds every flop, pulses included, so a stalled core sees them again
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      afterState <= ST_IDLE;
      savedPc <= '0;
      savedTarget <= '0;
      savedRel <= '0;
      savedImm <= '0;
      savedSp <= '0;
      savedHi <= '0;
      savedInt <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      pcLoad <= 1'b0;
      pcValue <= '0;
      carryWe <= 1'b0;
      carryOut <= 1'b0;
      bitWe <= 1'b0;
      bitAddrOut <= '0;
      bitOut <= 1'b0;
      byteWe <= 1'b0;
      byteOut <= '0;
      spWe <= 1'b0;
      spOut <= '0;
      prioRelease <= 1'b0;
      memReq <= 1'b0;
      memWe <= 1'b0;
      memAddr <= '0;
      memWdata <= '0;
    end else if (clkEn) begin
      state <= next_state;
      afterState <= next_afterState;
      savedPc <= next_savedPc;
      savedTarget <= next_savedTarget;
      savedRel <= next_savedRel;
      savedImm <= next_savedImm;
      savedSp <= next_savedSp;
      savedHi <= next_savedHi;
      savedInt <= next_savedInt;
      busy <= next_busy;
      done <= next_done;
      pcLoad <= next_pcLoad;
      pcValue <= next_pcValue;
      carryWe <= next_carryWe;
      carryOut <= next_carryOut;
      bitWe <= next_bitWe;
      bitAddrOut <= next_bitAddrOut;
      bitOut <= next_bitOut;
      byteWe <= next_byteWe;
      byteOut <= next_byteOut;
      spWe <= next_spWe;
      spOut <= next_spOut;
      prioRelease <= next_prioRelease;
      memReq <= next_memReq;
      memWe <= next_memWe;
      memAddr <= next_memAddr;
      memWdata <= next_memWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_CLR_C: assert property (take && opCode == OP_CLR_C |=> carryWe && !carryOut && !bitWe)
    else $error("carry clear failed");
  AST_CPL_BIT: assert property (take && opCode == OP_CPL_BIT |=>
    bitWe && bitOut == !$past(bitValue) && bitAddrOut == $past(bitAddr) && !carryWe)
    else $error("bit complement failed");
  AST_AND_NBIT: assert property (take && opCode == OP_AND_NBIT_C |=>
    carryWe && carryOut == ($past(carryIn) && !$past(bitValue)) && !bitWe)
    else $error("and inverted bit wrong");
  AST_OR_BIT: assert property (take && opCode == OP_OR_BIT_C |=>
    carryWe && carryOut == ($past(carryIn) || $past(bitValue)) && !bitWe)
    else $error("or bit wrong");
  AST_MOV_C_BIT: assert property (take && opCode == OP_MOV_C_BIT |=> bitWe && bitOut == $past(carryIn))
    else $error("carry to bit move wrong");
  AST_SHORT_JUMP: assert property (take && opCode == OP_SHORT_JUMP |=>
    pcLoad && pcValue == PC_W'($past(pcNext) + {{(PC_W-8){$past(relOffset[7])}}, $past(relOffset)}))
    else $error("short jump target wrong");
  AST_IND_JUMP: assert property (take && opCode == OP_INDIRECT_JUMP |=>
    pcLoad && pcValue == PC_W'($past(dataPointer) + $past(acc)))
    else $error("indirect jump target wrong");
  AST_ACC_ZERO: assert property (take && opCode == OP_ACC_ZERO |=> pcLoad == ($past(acc) == 8'h00))
    else $error("zero test branch wrong");
  AST_NO_CARRY: assert property (take && opCode == OP_NO_CARRY |=> pcLoad == !$past(carryIn) && !carryWe)
    else $error("carry test branch wrong");
  AST_BIT_ONE: assert property (take && opCode == OP_BIT_ONE |=> pcLoad == $past(bitValue) && !bitWe)
    else $error("bit test branch wrong");
  AST_TEST_CLEAR: assert property (take && opCode == OP_BIT_TEST_CLEAR |=>
    pcLoad == $past(bitValue) && bitWe == $past(bitValue) && !bitOut)
    else $error("test and clear wrong");
  AST_CMP_IND: assert property (take && opCode == OP_CMP_INDIRECT ##1 clkEn ##1 clkEn |=> done && carryWe)
    else $error("indirect compare did not finish");
  AST_CMP_READ: assert property (take && opCode == OP_CMP_INDIRECT |=>
    memReq && !memWe && memAddr == $past(ptrAddr) && !done)
    else $error("indirect compare read wrong");
  AST_CMP_CARRY: assert property (take && opCode == OP_CMP |=> carryWe &&
    carryOut == ($past(operandA) < $past(operandB)) && pcLoad == ($past(operandA) != $past(operandB)))
    else $error("compare result wrong");
  AST_DEC: assert property (take && opCode == OP_DEC_BRANCH |=>
    byteWe && byteOut == 8'($past(operandA) - 8'h01) && pcLoad == (byteOut != 8'h00))
    else $error("decrement branch wrong");
  AST_NOP: assert property (take && opCode == OP_NOP |=>
    done && !busy && !pcLoad && !carryWe && !bitWe && !byteWe && !memReq && !spWe)
    else $error("no-op changed state");
  AST_CALL: assert property (take && opCode == OP_CALL |=>
    memWe && memAddr == 8'($past(spIn) + 8'h01) && memWdata == $past(pcNext[7:0]))
    else $error("call push wrong");
  AST_RELEASE: assert property (prioRelease |-> pcLoad && spWe && done)
    else $error("priority release outside return");

  CVR_CALL: cover property (take && opCode == OP_CALL ##2 done);
  CVR_TEST_CLEAR: cover property (take && opCode == OP_BIT_TEST_CLEAR && bitValue);
  CVR_INT_RETURN: cover property (prioRelease);
  CVR_CMP_IND: cover property (take && opCode == OP_CMP_INDIRECT ##3 pcLoad);
endmodule // bbe_exec

// *** testbench.sv ***
// self-checking bench for the bit and branch execution unit
// assumes bbe_pkg and bbe_exec are compiled first; the bench plays datapath and internal ram
`timescale 1ns/1ps
module testbench import bbe_pkg::*; ();
  localparam int PCW = 16;
  ////////////////////////////////////////////////////////////////////////////////
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic opValid = 1'b0;
  bbe_op_e opCode = OP_NOP;
  logic [PCW-1:0] pcNext = 16'h0000;
  logic [7:0] relOffset = 8'h00;
  logic [PCW-1:0] target = 16'h0000;
  logic [7:0] acc = 8'h00;
  logic [PCW-1:0] dataPointer = 16'h0000;
  logic carryIn = 1'b0;
  logic [7:0] bitAddr = 8'h00;
  logic bitValue = 1'b0;
  logic [7:0] operandA = 8'h00;
  logic [7:0] operandB = 8'h00;
  logic [7:0] ptrAddr = 8'h00;
  logic [7:0] spIn = 8'h00;
  logic [7:0] memRdata = 8'h00;
  logic busy, done, pcLoad, carryWe, carryOut, bitWe, bitOut, byteWe, spWe, prioRelease, memReq, memWe;
  logic [PCW-1:0] pcValue;
  logic [7:0] bitAddrOut, byteOut, spOut, memAddr, memWdata;
  logic [7:0] mem [256];
  int error_cnt = 0;
  int cmp_count = 0;
  bit enRand = 1'b0;

  always #5 clk = ~clk;

  // stalls only in the late phase, so latency counts stay exact elsewhere
  always @(posedge clk) clkEn <= enRand ? ($urandom % 4 != 0) : 1'b1;

  // one-cycle ram; an idle read bus shows the inverse of its last value
  always @(posedge clk) begin
    if (clkEn) begin
      if (memReq) memRdata <= mem[memAddr];
      else memRdata <= ~memRdata;
      if (memReq && memWe) mem[memAddr] <= memWdata;
    end
  end

  bbe_exec #(.PC_W(PCW)) dut_u (
    .clk(clk), .resetn(resetn), .clkEn(clkEn), .opValid(opValid), .opCode(opCode), .pcNext(pcNext),
    .relOffset(relOffset), .target(target), .acc(acc), .dataPointer(dataPointer), .carryIn(carryIn),
    .bitAddr(bitAddr), .bitValue(bitValue), .operandA(operandA), .operandB(operandB), .ptrAddr(ptrAddr),
    .spIn(spIn), .memRdata(memRdata), .busy(busy), .done(done), .pcLoad(pcLoad), .pcValue(pcValue),
    .carryWe(carryWe), .carryOut(carryOut), .bitWe(bitWe), .bitAddrOut(bitAddrOut), .bitOut(bitOut),
    .byteWe(byteWe), .byteOut(byteOut), .spWe(spWe), .spOut(spOut), .prioRelease(prioRelease),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // drive one request with random operands biased to boundaries, then compare at done
  task automatic run_op(input bbe_op_e op);
    logic [7:0] a, p, m, eSp, eB;
    logic [PCW-1:0] rt, ePc;
    logic eCw, eC, eBw, eByw, ePl, eSw, ePr;
    int n, lat, r;
    @(posedge clk);
    a = ($urandom % 4 == 0) ? 8'h01 : 8'($urandom);
    p = 8'($urandom);
    r = $urandom % 4;
    opValid <= 1'b1;
    opCode <= op;
    pcNext <= 16'($urandom);
    relOffset <= (r == 0) ? 8'h7F : (r == 1) ? 8'h80 : 8'($urandom);
    target <= 16'($urandom);
    acc <= ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
    dataPointer <= 16'($urandom);
    carryIn <= 1'($urandom);
    bitAddr <= 8'($urandom);
    bitValue <= 1'($urandom);
    operandA <= a;
    ptrAddr <= p;
    operandB <= ($urandom % 3 == 0) ? ((op == OP_CMP_INDIRECT) ? mem[p] : a) : 8'($urandom);
    spIn <= 8'($urandom);
    do @(posedge clk); while (clkEn !== 1'b1);
    opValid <= 1'b0;
    n = 1;
    #1;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      if (clkEn) n++;
      #1;
    end
    rt = pcNext + {{8{relOffset[7]}}, relOffset};
    {eCw, eC, eBw, eB, eByw, ePl, eSw, ePr} = '0;
    ePc = rt;
    eSp = 8'h00;
    lat = 1;
    case (op)
      OP_CLR_C, OP_SET_C, OP_CPL_C: begin eCw = 1; eC = (op == OP_SET_C) | ((op == OP_CPL_C) & ~carryIn); end
      OP_CLR_BIT, OP_SET_BIT, OP_CPL_BIT: begin eBw = 1; eB = {7'h00, (op == OP_SET_BIT) | ((op == OP_CPL_BIT) & ~bitValue)}; end
      OP_AND_BIT_C: begin eCw = 1; eC = carryIn & bitValue; end
      OP_AND_NBIT_C: begin eCw = 1; eC = carryIn & ~bitValue; end
      OP_OR_BIT_C: begin eCw = 1; eC = carryIn | bitValue; end
      OP_OR_NBIT_C: begin eCw = 1; eC = carryIn | ~bitValue; end
      OP_MOV_BIT_C: begin eCw = 1; eC = bitValue; end
      OP_MOV_C_BIT: begin eBw = 1; eB = {7'h00, carryIn}; end
      OP_SHORT_JUMP: ePl = 1;
      OP_INDIRECT_JUMP: begin ePl = 1; ePc = dataPointer + {8'h00, acc}; end
      OP_ABS_JUMP: begin ePl = 1; ePc = target; end
      OP_ACC_ZERO: ePl = (acc == 8'h00);
      OP_ACC_NONZERO: ePl = (acc != 8'h00);
      OP_CARRY: ePl = carryIn;
      OP_NO_CARRY: ePl = ~carryIn;
      OP_BIT_ONE: ePl = bitValue;
      OP_BIT_ZERO: ePl = ~bitValue;
      OP_BIT_TEST_CLEAR: begin ePl = bitValue; eBw = bitValue; end
      OP_CMP, OP_CMP_INDIRECT: begin
        m = (op == OP_CMP) ? operandA : mem[ptrAddr];
        lat = (op == OP_CMP) ? 1 : 3;
        eCw = 1;
        eC = (m < operandB);
        ePl = (m != operandB);
      end
      OP_DEC_BRANCH: begin eByw = 1; ePl = (operandA != 8'h01); end
      OP_CALL: begin lat = 2; ePl = 1; ePc = target; eSw = 1; eSp = spIn + 8'h02; end
      OP_RETURN, OP_INT_RETURN: begin
        lat = 5;
        ePl = 1;
        ePc = {mem[spIn], mem[spIn - 8'h01]};
        eSw = 1;
        eSp = spIn - 8'h02;
        ePr = (op == OP_INT_RETURN);
      end
      default: ;
    endcase
    chk(n == lat, $sformatf("latency op %0d got %0d", op, n));
    chk(done === 1'b1 && carryWe === eCw && bitWe === eBw && byteWe === eByw && spWe === eSw && pcLoad === ePl
        && prioRelease === ePr, $sformatf("strobes op %0d", op));
    if (eCw) chk(carryOut === eC, $sformatf("carry op %0d", op));
    if (eBw) chk(bitAddrOut === bitAddr && bitOut === eB[0], $sformatf("bit op %0d", op));
    if (ePl) chk(pcValue === ePc, $sformatf("pc op %0d", op));
    if (eByw) chk(byteOut === operandA - 8'h01, "decrement value");
    if (eSw) chk(spOut === eSp, $sformatf("stack pointer op %0d", op));
    if (op == OP_CALL) chk(memWdata === pcNext[15:8] && memAddr === spIn + 8'h02
        && mem[spIn + 8'h01] === pcNext[7:0], "return address push");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    void'($urandom(52));
    // ram contents are drawn after seeding so every run sees the same stack and pointer data
    for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
    repeat (12) @(posedge clk);
    chk(busy === 1'b0 && done === 1'b0 && pcLoad === 1'b0 && memReq === 1'b0 && spWe === 1'b0, "reset state");
    resetn <= 1'b1;
    for (int i = 0; i < 32; i++) run_op(bbe_op_e'(i[4:0]));
    repeat (400) run_op(bbe_op_e'(5'($urandom)));
    // reset in the middle of a stack pop must abandon it cleanly
    @(posedge clk);
    opValid <= 1'b1;
    opCode <= OP_RETURN;
    @(posedge clk);
    opValid <= 1'b0;
    @(posedge clk);
    resetn <= 1'b0;
    #1;
    chk(busy === 1'b0 && memReq === 1'b0 && done === 1'b0 && pcLoad === 1'b0, "mid-run reset");
    @(posedge clk);
    resetn <= 1'b1;
    run_op(OP_INT_RETURN);
    enRand = 1'b1;
    repeat (200) run_op(bbe_op_e'(5'($urandom)));
    enRand = 1'b0;
    conclude();
  end
endmodule // testbench
